// ==== rtl/gtu_top.sv ====
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module gtu_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic [gtu_pkg::ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [gtu_pkg::DATA_W-1:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [gtu_pkg::ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [gtu_pkg::DATA_W-1:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic [gtu_pkg::NUM_TMR-1:0] timer_input_pin_in,
  input wire logic [gtu_pkg::NUM_TMR-1:0] direction_input_pin_in,
  input wire logic capture_input_pin_in,
  output logic core_toggle_output_out,
  output logic core_toggle_output_en_out,
  output logic second_toggle_output_out,
  output logic second_toggle_output_en_out,
  output logic external_compare_timers_clk_out
);
  import gtu_pkg::*;

  // true when the low nbits of the divider are all ones
  function automatic logic pre_tick(input logic [15:0] div,
                                    input logic [3:0] nbits);
    logic [15:0] mask;
    mask = ~(16'hffff << nbits);
    return (div & mask) == mask;
  endfunction

  // edge select: 1 rising, 2 falling, 3 both, 0 none
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic rise, input logic fall);
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // register state
  logic [15:0] ctrl_ff [NUM_TMR]; // per-timer control
  logic [15:0] cnt_ff [NUM_TMR]; // timer values
  logic [15:0] nxt_cnt [NUM_TMR];
  logic [15:0] capreg_ff; // capture_reload_reg
  logic [15:0] nxt_capreg;
  logic [15:0] flags_ff; // sticky event flags
  logic [15:0] nxt_flags;
  logic lat1_ff; // core_toggle_latch
  logic lat2_ff; // second_toggle_latch
  logic cmp_ff; // pulse toward the compare timers
  logic [15:0] div_ff; // free-running prescaler base

  // pin synchronisers: stage 1 feeds only stage 2
  logic [NUM_PIN-1:0] sy1_ff;
  logic [NUM_PIN-1:0] sy2_ff;
  logic [NUM_PIN-1:0] sy3_ff; // previous level for edge detection
  wire [NUM_PIN-1:0] lvl = sy2_ff;
  wire [NUM_PIN-1:0] rise = sy2_ff & ~sy3_ff;
  wire [NUM_PIN-1:0] fall = ~sy2_ff & sy3_ff;

  // bus slave state
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  // per-timer event wires
  logic [NUM_TMR-1:0] cnt_ev; // count pulse this cycle
  logic [NUM_TMR-1:0] cnt_dn; // counting down
  logic [NUM_TMR-1:0] ovf; // overflow or underflow
  logic [NUM_TMR-1:0] rld; // aux reload request into the core
  logic [NUM_TMR-1:0] cap; // aux capture of the core
  logic [15:0] step [NUM_TMR];

  // core latch transitions, known before the edge
  wire lat_rise = ovf[T_CORE] & ~lat1_ff;
  wire lat_fall = ovf[T_CORE] & lat1_ff;

  genvar g;
  for (g = 0; g < NUM_TMR; g++) begin : g_tmr
    wire [15:0] c = ctrl_ff[g];
    wire [2:0] mode = c[F_MODE_HI:F_MODE_LO];
    wire [1:0] src = c[1:0];
    wire [1:0] esel = c[F_EDGE_HI:F_EDGE_LO];
    wire [3:0] pre = {1'b0, c[F_PRE_HI:F_PRE_LO]};
    wire pin_ev = edge_hit(esel, rise[g], fall[g]);
    // encoder: A on the input pin, B on the direction pin
    wire qa = rise[g] | fall[g];
    wire qb = rise[g+5] | fall[g+5];
    wire qup = qa ? (lvl[g] != lvl[g+5]) : (lvl[g] == lvl[g+5]);
    wire sw_dn = c[F_DOWN] ^ (c[F_EXTDIR] & lvl[g+5]);
    if (g < 3) begin : g_one
      wire tick = pre_tick(div_ff, G1_BASE_BITS + pre);
      wire lat_ev = (g != T_CORE) && mode == M_LATCH &&
                    edge_hit(esel, lat_rise, lat_fall);
      // reload and capture modes fall through to no counting
      assign cnt_ev[g] = c[F_RUN] & (
        (mode == M_TIMER) ? tick :
        (mode == M_GATED) ? tick & lvl[g] :
        (mode == M_COUNTER) ? pin_ev :
        (mode == M_QUAD) ? qa | qb : lat_ev);
      assign cnt_dn[g] = (mode == M_QUAD) ? ~qup : sw_dn;
      assign rld[g] = (g != T_CORE) && mode == M_RELOAD &&
        ((c[F_LATR] & lat_rise) | (c[F_LATF] & lat_fall) | pin_ev);
      assign cap[g] = (g != T_CORE) && mode == M_CAPTURE && pin_ev;
    end else begin : g_two
      wire tick = pre_tick(div_ff, G2_BASE_BITS + pre);
      wire lat_ev = (g == T_AUX_C) && ovf[T_CORE2];
      assign cnt_ev[g] = c[F_RUN] & (
        (src == S_PRE) ? tick :
        (src == S_PIN) ? rise[g] :
        (src == S_LATCH) ? lat_ev : 1'b0);
      assign cnt_dn[g] = sw_dn;
      assign rld[g] = 1'b0;
      assign cap[g] = 1'b0;
    end
    // a wrap past either end of the 16-bit range
    assign ovf[g] = cnt_ev[g] &
      (cnt_dn[g] ? cnt_ff[g] == 16'h0000 : cnt_ff[g] == 16'hffff);
    assign step[g] = cnt_dn[g] ? cnt_ff[g] - 16'h0001 :
                                 cnt_ff[g] + 16'h0001;
  end

  // capture trigger into capture_reload_reg, from its pin or core pins
  wire [1:0] csel = ctrl_ff[T_AUX_C][F_EDGE_HI:F_EDGE_LO];
  wire use_core_pins = ctrl_ff[T_AUX_C][F_TRIG_CNT] |
                       ctrl_ff[T_AUX_C][F_TRIG_DIR];
  wire core_pin_ev = (ctrl_ff[T_AUX_C][F_TRIG_CNT] &
      edge_hit(csel, rise[T_CORE], fall[T_CORE])) |
    (ctrl_ff[T_AUX_C][F_TRIG_DIR] &
      edge_hit(csel, rise[T_CORE+5], fall[T_CORE+5]));
  wire cap2 = use_core_pins ? core_pin_ev :
              edge_hit(csel, rise[10], fall[10]);
  wire rld2 = ovf[T_CORE2] & ctrl_ff[T_CORE2][F_RLD2];

  // bus decode
  wire wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire [4:0] wr_idx = aw_addr_ff[6:2];
  wire wr_map = ~aw_addr_ff[7] && wr_idx <= IDX_STATE;
  wire [4:0] rd_idx = araddr_in[6:2];
  wire rd_map = ~araddr_in[7] && rd_idx <= IDX_STATE;
  wire ar_take = arvalid_in & arready_out;
  wire [15:0] w1c = merge16(16'h0000, w_data_ff, w_strb_ff);
  assign awready_out = clk_en_in & ~aw_got_ff & ~bvalid_ff;
  assign wready_out = clk_en_in & ~w_got_ff & ~bvalid_ff;
  assign arready_out = clk_en_in & ~rvalid_ff;

  // read data selection
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    if (rd_idx < IDX_CNT0) begin
      rd_val = ctrl_ff[3'(rd_idx)];
    end else if (rd_idx < IDX_CAPREG) begin
      rd_val = cnt_ff[3'(rd_idx - IDX_CNT0)];
    end else if (rd_idx == IDX_CAPREG) begin
      rd_val = capreg_ff;
    end else if (rd_idx == IDX_FLAGS) begin
      rd_val = flags_ff;
    end else if (rd_idx == IDX_STATE) begin
      rd_val = {14'h0000, lat2_ff, lat1_ff};
    end
  end

  // next values: counting, then reload and capture, then software writes
  always_comb begin
    for (int i = 0; i < NUM_TMR; i++) begin
      nxt_cnt[i] = cnt_ev[i] ? step[i] : cnt_ff[i];
    end
    nxt_capreg = capreg_ff;
    // one reload source wins; alternating latch edges give PWM
    if (rld[T_AUX_A]) begin
      nxt_cnt[T_CORE] = cnt_ff[T_AUX_A];
    end else if (rld[T_AUX_B]) begin
      nxt_cnt[T_CORE] = cnt_ff[T_AUX_B];
    end
    if (cap[T_AUX_A]) begin
      nxt_cnt[T_AUX_A] = cnt_ff[T_CORE];
    end
    if (cap[T_AUX_B]) begin
      nxt_cnt[T_AUX_B] = cnt_ff[T_CORE];
    end
    if (rld2) begin
      nxt_cnt[T_CORE2] = capreg_ff;
    end
    if (cap2) begin
      nxt_capreg = cnt_ff[T_AUX_C];
      if (ctrl_ff[T_AUX_C][F_CLRCAP]) begin
        nxt_cnt[T_AUX_C] = 16'h0000;
      end
    end
    // a software write to a value register takes priority
    if (wr_fire && wr_idx >= IDX_CNT0 && wr_idx < IDX_CAPREG) begin
      nxt_cnt[3'(wr_idx - IDX_CNT0)] =
        merge16(cnt_ff[3'(wr_idx - IDX_CNT0)], w_data_ff, w_strb_ff);
    end
    if (wr_fire && wr_idx == IDX_CAPREG) begin
      nxt_capreg = merge16(capreg_ff, w_data_ff, w_strb_ff);
    end
    // write-one-to-clear, but a same-cycle event still sets its flag
    nxt_flags = flags_ff & ~((wr_fire && wr_idx == IDX_FLAGS) ?
                             w1c : 16'h0000);
    nxt_flags[4:0] = nxt_flags[4:0] | ovf;
    nxt_flags[FL_EVT_A] = nxt_flags[FL_EVT_A] |
                          rld[T_AUX_A] | cap[T_AUX_A];
    nxt_flags[FL_EVT_B] = nxt_flags[FL_EVT_B] |
                          rld[T_AUX_B] | cap[T_AUX_B];
    nxt_flags[FL_CAP2] = nxt_flags[FL_CAP2] | cap2;
    nxt_flags[FL_RLD2] = nxt_flags[FL_RLD2] | rld2;
  end

  // synchronisers hold with the rest of the state while the enable is low
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sy1_ff <= '0;
      sy2_ff <= '0;
    end else if (clk_en_in) begin
      sy1_ff <= {capture_input_pin_in, direction_input_pin_in,
                 timer_input_pin_in};
      sy2_ff <= sy1_ff;
    end
  end

  // timer datapath
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sy3_ff <= '0;
      div_ff <= REG_RST;
      capreg_ff <= REG_RST;
      flags_ff <= REG_RST;
      lat1_ff <= 1'b0;
      lat2_ff <= 1'b0;
      cmp_ff <= 1'b0;
      for (int i = 0; i < NUM_TMR; i++) begin
        cnt_ff[i] <= REG_RST;
        ctrl_ff[i] <= REG_RST;
      end
    end else if (clk_en_in) begin
      sy3_ff <= sy2_ff;
      div_ff <= div_ff + 16'h0001;
      capreg_ff <= nxt_capreg;
      flags_ff <= nxt_flags;
      lat1_ff <= lat1_ff ^ ovf[T_CORE];
      lat2_ff <= lat2_ff ^ ovf[T_CORE2];
      cmp_ff <= ovf[T_CORE2];
      for (int i = 0; i < NUM_TMR; i++) begin
        cnt_ff[i] <= nxt_cnt[i];
      end
      if (wr_fire && wr_idx < IDX_CNT0) begin
        ctrl_ff[3'(wr_idx)] <=
          merge16(ctrl_ff[3'(wr_idx)], w_data_ff, w_strb_ff);
      end
    end
  end

  // bus slave: address and data in either order, one at a time
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
    end else if (clk_en_in) begin
      if (awvalid_in && awready_out) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_got_ff <= 1'b1;
        w_data_ff <= wdata_in;
        w_strb_ff <= wstrb_in;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_in) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= {16'h0000, rd_val};
        rresp_ff <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rready_in) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign bvalid_out = bvalid_ff;
  assign bresp_out = bresp_ff;
  assign rvalid_out = rvalid_ff;
  assign rresp_out = rresp_ff;
  assign rdata_out = rdata_ff;
  assign core_toggle_output_out = lat1_ff;
  assign core_toggle_output_en_out = ctrl_ff[T_CORE][F_OUTEN];
  assign second_toggle_output_out = lat2_ff;
  assign second_toggle_output_en_out = ctrl_ff[T_CORE2][F_OUTEN];
  assign external_compare_timers_clk_out = cmp_ff;

  // checks
  chk_core_latch_flip: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    clk_en_in && ovf[T_CORE] |=> lat1_ff != $past(lat1_ff))
    else $error("core latch missed a toggle");
  chk_aux_capture_copy: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    clk_en_in && cap[T_AUX_A] && !wr_fire |=>
      cnt_ff[T_AUX_A] == $past(cnt_ff[T_CORE]))
    else $error("aux capture value wrong");
  chk_core_reload_load: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    clk_en_in && rld[T_AUX_B] && !rld[T_AUX_A] && !wr_fire |=>
      cnt_ff[T_CORE] == $past(cnt_ff[T_AUX_B]))
    else $error("core reload value wrong");
  chk_aux_held_stopped: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    clk_en_in && ctrl_ff[T_AUX_A][F_MODE_HI:F_MODE_LO] == M_RELOAD &&
      !wr_fire |=> $stable(cnt_ff[T_AUX_A]))
    else $error("reload aux timer moved");
  chk_g1_tick_spacing: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    cnt_ev[T_CORE] && ctrl_ff[T_CORE][F_MODE_HI:F_MODE_LO] == M_TIMER
      |-> div_ff[1:0] == 2'h3)
    else $error("group one counted faster than four cycles");
  chk_g2_tick_spacing: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    cnt_ev[T_CORE2] && ctrl_ff[T_CORE2][1:0] == S_PRE |-> div_ff[0])
    else $error("group two counted faster than two cycles");
  chk_cap_clear_aux: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    clk_en_in && cap2 && ctrl_ff[T_AUX_C][F_CLRCAP] && !wr_fire |=>
      capreg_ff == $past(cnt_ff[T_AUX_C]) && cnt_ff[T_AUX_C] == 16'h0000)
    else $error("capture with clear failed");
  chk_cmp_clk_pulse: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    clk_en_in && ovf[T_CORE2] |=> external_compare_timers_clk_out)
    else $error("compare clock pulse missing");
  chk_ovf_flag_set: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    clk_en_in && ovf != 5'h00 |=> (flags_ff[4:0] & $past(ovf)) == $past(ovf))
    else $error("overflow flag not set");
  chk_gate_low_hold: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    clk_en_in && ctrl_ff[T_CORE][F_MODE_HI:F_MODE_LO] == M_GATED &&
      !lvl[T_CORE] && !rld[T_AUX_A] && !rld[T_AUX_B] && !wr_fire
      |=> $stable(cnt_ff[T_CORE]))
    else $error("gated timer counted with gate low");
endmodule // gtu_top
`default_nettype wire

// ==== rtl/gtu_pkg.sv ====
package gtu_pkg;
  // bus and datapath widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NUM_TMR = 5;
  localparam int unsigned NUM_PIN = 11;
  // word indices: timer k sits at IDX_CTRL0+k and IDX_CNT0+k
  localparam logic [4:0] IDX_CTRL0 = 5'h00;
  localparam logic [4:0] IDX_CNT0 = 5'h05;
  localparam logic [4:0] IDX_CAPREG = 5'h0a;
  localparam logic [4:0] IDX_FLAGS = 5'h0b;
  localparam logic [4:0] IDX_STATE = 5'h0c;
  // timer index inside the arrays
  localparam int unsigned T_AUX_A = 0;
  localparam int unsigned T_CORE = 1;
  localparam int unsigned T_AUX_B = 2;
  localparam int unsigned T_AUX_C = 3;
  localparam int unsigned T_CORE2 = 4;
  // control field positions
  localparam int unsigned F_MODE_LO = 0;
  localparam int unsigned F_MODE_HI = 2;
  localparam int unsigned F_RUN = 3;
  localparam int unsigned F_DOWN = 4;
  localparam int unsigned F_EXTDIR = 5;
  localparam int unsigned F_PRE_LO = 6;
  localparam int unsigned F_PRE_HI = 8;
  localparam int unsigned F_EDGE_LO = 9;
  localparam int unsigned F_EDGE_HI = 10;
  localparam int unsigned F_LATR = 11;
  localparam int unsigned F_LATF = 12;
  localparam int unsigned F_CLRCAP = 11;
  localparam int unsigned F_TRIG_CNT = 12;
  localparam int unsigned F_TRIG_DIR = 13;
  localparam int unsigned F_OUTEN = 13;
  localparam int unsigned F_RLD2 = 14;
  // group one modes
  localparam logic [2:0] M_TIMER = 3'h0;
  localparam logic [2:0] M_GATED = 3'h1;
  localparam logic [2:0] M_COUNTER = 3'h2;
  localparam logic [2:0] M_QUAD = 3'h3;
  localparam logic [2:0] M_RELOAD = 3'h4;
  localparam logic [2:0] M_CAPTURE = 3'h5;
  localparam logic [2:0] M_LATCH = 3'h6;
  // group two clock sources
  localparam logic [1:0] S_PRE = 2'h0;
  localparam logic [1:0] S_PIN = 2'h1;
  localparam logic [1:0] S_LATCH = 2'h2;
  // flag bits
  localparam int unsigned FL_EVT_A = 5;
  localparam int unsigned FL_EVT_B = 6;
  localparam int unsigned FL_CAP2 = 7;
  localparam int unsigned FL_RLD2 = 8;
  // reset values
  localparam logic [15:0] REG_RST = 16'h0000;
  // finest resolutions in system clock cycles, as shift counts
  localparam int unsigned G1_RES_CYCLES = 4;
  localparam int unsigned G2_RES_CYCLES = 2;
  localparam logic [3:0] G1_BASE_BITS = 4'($clog2(G1_RES_CYCLES));
  localparam logic [3:0] G2_BASE_BITS = 4'($clog2(G2_RES_CYCLES));
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verification/gtu_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// far-side model of the event pins
// every pin idles low and is always driven, so no level is ever left floating
module gtu_pin_model (
  input wire logic clk_in,
  output logic [4:0] tin_out,
  output logic [4:0] dir_out,
  output logic cap_out
);
  int q = 0; // encoder phase, kept across calls so a and b stay consistent
  // idle levels from time zero
  initial begin
    tin_out = '0;
    dir_out = '0;
    cap_out = 1'b0;
  end
  // k 0..4 input pins, 5 capture pin, 6..10 direction pins
  task automatic drive(input int k, input bit v);
    if (k < 5) tin_out[k] <= v;
    else if (k == 5) cap_out <= v;
    else dir_out[k - 6] <= v;
  endtask
  // change one pin just after a rising edge
  task automatic set(input int k, input bit v);
    @(posedge clk_in);
    drive(k, v);
  endtask
  // each level lasts 4 cycles, long enough for the two-flop synchroniser
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      set(k, 1'b1);
      repeat (3) @(posedge clk_in);
      set(k, 1'b0);
      repeat (3) @(posedge clk_in);
    end
  endtask
  // encoder: a on the core input pin, b on the core direction pin
  task automatic quad(input int n, input bit fwd);
    repeat (n) begin
      q = fwd ? (q + 1) % 4 : (q + 3) % 4;
      @(posedge clk_in);
      tin_out[1] <= (q == 1 || q == 2);
      dir_out[1] <= (q >= 2);
      repeat (3) @(posedge clk_in);
    end
  endtask
endmodule // gtu_pin_model
`default_nettype wire

// ==== verification/test_gtu_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_gtu_top;
  import gtu_pkg::*;
  logic clk_in;
  logic reset_n_in;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [4:0] tin, dirp;
  wire logic cap, lat1, en1, lat2, en2, ext;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0; // index of the current edge
  int t0 = 0; // edge at which the last read address was taken
  int align = 1; // read address is taken on an edge t0 + n * align
  int pc = 0; // compare-clock pulses seen
  int seed = 32'h3461f1ed;
  int p, dn, ed, pv, per, v, tb, cr, np, l;
  int eq[$];
  int lq[$];
  logic [31:0] d;
  logic [1:0] r;
  logic en; // clock enable toward the design
  logic [3:0] strb; // write byte lanes

  gtu_top i_gtu_top (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .clk_en_in(en), .awaddr_in(awaddr), .awvalid_in(awvalid),
    .awready_out(awready), .wdata_in(wdata), .wstrb_in(strb),
    .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
    .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr),
    .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
    .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
    .timer_input_pin_in(tin), .direction_input_pin_in(dirp),
    .capture_input_pin_in(cap), .core_toggle_output_out(lat1),
    .core_toggle_output_en_out(en1), .second_toggle_output_out(lat2),
    .second_toggle_output_en_out(en2),
    .external_compare_timers_clk_out(ext));
  gtu_pin_model pins (.clk_in(clk_in), .tin_out(tin), .dir_out(dirp),
    .cap_out(cap));

  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // edge counter and compare-clock pulse counter
  always @(posedge clk_in) cyc <= cyc + 1;
  always @(posedge clk_in) if (ext === 1'b1) pc <= pc + 1;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_w(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_r(input string n, input logic [1:0] e,
                       input logic [1:0] g);
    chk_w(n, 32'(e), 32'(g));
  endtask
  // value register of timer k
  function automatic logic [7:0] va(input int k);
    return 8'(4 * (int'(IDX_CNT0) + k));
  endfunction
  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dd,
                    input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] s = 4'hf);
    @(posedge clk_in);
    awaddr <= a;
    strb <= s;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge clk_in); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge clk_in); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge clk_in); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_r("bresp", er, bresp);
  endtask
  // one read; the address waits for an edge on the align grid so that
  // two reads of a running timer lie a whole number of ticks apart
  task automatic rd(input logic [7:0] a, output logic [31:0] dd,
                    output logic [1:0] rr);
    do @(posedge clk_in); while ((cyc + 1 - t0) % align != 0);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    t0 = cyc;
    do @(posedge clk_in); while (rvalid !== 1'b1);
    rready <= 1'b0;
    dd = rdata;
    rr = rresp;
  endtask
  task automatic rv(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] dd;
    logic [1:0] rr;
    rd(a, dd, rr);
    chk_r("rresp", RESP_OKAY, rr);
    chk_w($sformatf("reg %h", a), e, dd);
  endtask

  // a hang ends the run as a failure
  initial begin
    repeat (30000) @(posedge clk_in);
    bad_count++;
    stop_test();
  end

  // main sequence
  initial begin
    reset_n_in = 1'b0;
    en = 1'b1;
    strb = 4'hf;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 13; i++) rv(8'(4 * i), 32'h0);
    rd(8'h34, d, r);
    chk_r("rresp", RESP_SLVERR, r);
    chk_w("rdata", 32'h0, d);
    wr(8'h80, 32'h1, RESP_SLVERR);
    wr(va(1), 32'hffffffff);
    rv(va(1), 32'h0000ffff);
    // only the upper byte lane is written
    wr(va(1), 32'h1234abcd, RESP_OKAY, 4'h2);
    rv(va(1), 32'h0000abff);
    // prescaled rates, software and pin direction, every timer
    for (int k = 0; k < 5; k++) begin
      p = $random(seed) & 3;
      dn = $random(seed) & 1;
      ed = $random(seed) & 1;
      pv = $random(seed) & 1;
      per = (k < 3 ? 4 : 2) << p;
      pins.set(k + 6, pv[0]);
      // a mid-range start keeps both toggle latches still here
      wr(va(k), 32'($random(seed) & 16'h7fff) + 32'h4000);
      wr(8'(4 * k), 32'(8 | dn << 4 | ed << 5 | p << 6));
      rd(va(k), d, r);
      v = d[15:0];
      tb = t0;
      repeat (37) @(posedge clk_in);
      align = per;
      rd(va(k), d, r);
      align = 1;
      v += ((dn ^ (ed & pv)) ? -1 : 1) * (t0 - tb) / per;
      chk_w("rate", v & 32'hffff, d);
      wr(8'(4 * k), 32'h0);
      pins.set(k + 6, 1'b0);
    end
    // gated: a 48-cycle gate at prescale 1 gives exactly 6 ticks
    wr(va(1), 32'h0);
    wr(8'h04, 32'(M_GATED) | 32'h48);
    pins.set(1, 1'b1);
    repeat (47) @(posedge clk_in);
    pins.set(1, 1'b0);
    repeat (6) @(posedge clk_in);
    rv(va(1), 32'd6);
    // counter mode on the rising, falling and both-edge selections
    for (int e = 1; e < 4; e++) begin
      wr(va(1), 32'h0);
      wr(8'h04, 32'(M_COUNTER) | 32'h8 | 32'(e << 9));
      pins.pulse(1, 5);
      rv(va(1), e == 3 ? 32'd10 : 32'd5);
    end
    wr(va(4), 32'h0);
    wr(8'h10, 32'(S_PIN) | 32'h8);
    pins.pulse(4, 7);
    rv(va(4), 32'd7);
    wr(8'h10, 32'h0);
    // encoder steps forward, then back past the start
    wr(va(1), 32'h100);
    wr(8'h04, 32'(M_QUAD) | 32'h8);
    pins.quad(9, 1'b1);
    rv(va(1), 32'h109);
    pins.quad(13, 1'b0);
    rv(va(1), 32'h0fc);
    // core overflow toggles its latch, which clocks aux_b
    wr(va(1), 32'hfff0);
    wr(va(2), 32'h0);
    wr(8'h08, 32'(M_LATCH) | 32'h608);
    wr(8'h2c, 32'h1ff);
    wr(8'h04, 32'h2008);
    repeat (90) @(posedge clk_in);
    wr(8'h04, 32'h2000);
    chk_w("t_out", 32'h1, 32'(lat1));
    chk_w("t_en", 32'h1, 32'(en1));
    rv(va(2), 32'h1);
    rv(8'h30, 32'h1);
    // capture into aux_a with the core stopped, then reload from it
    v = $random(seed) & 16'hffff;
    wr(va(1), 32'(v));
    wr(8'h00, 32'(M_CAPTURE) | 32'h208);
    pins.pulse(0, 1);
    repeat (30) @(posedge clk_in);
    rv(va(0), 32'(v));
    rv(8'h2c, 32'h22);
    wr(va(1), 32'h0);
    wr(8'h00, 32'(M_RELOAD) | 32'h208);
    pins.pulse(0, 1);
    rv(va(1), 32'(v));
    // alternate reloads on opposite latch edges: high 6 ticks, low 10
    wr(va(0), 32'd5);
    wr(va(2), 32'd9);
    wr(va(1), 32'd3);
    wr(8'h00, 32'(M_RELOAD) | 32'h808);
    wr(8'h08, 32'(M_RELOAD) | 32'h1008);
    wr(8'h04, 32'h2018);
    l = lat1;
    repeat (400) begin
      @(posedge clk_in);
      if (lat1 !== l[0]) begin
        eq.push_back(cyc);
        lq.push_back(lat1);
      end
      l = lat1;
    end
    wr(8'h04, 32'h0);
    chk_w("edges", 32'h1, 32'(eq.size() > 9));
    for (int i = 0; i + 1 < eq.size(); i++)
      chk_w("pwm", lq[i] ? 32'd24 : 32'd40, eq[i + 1] - eq[i]);
    // aux_c into capture_reload_reg, with clear afterwards
    v = $random(seed) & 16'hffff;
    wr(va(3), 32'(v));
    wr(8'h0c, 32'h0a00);
    pins.pulse(5, 1);
    rv(8'h28, 32'(v));
    rv(va(3), 32'h0);
    cr = v;
    // capture from the core input pin, then the core direction pin
    for (int b = 12; b < 14; b++) begin
      v = $random(seed) & 16'hffff;
      wr(va(3), 32'(v));
      wr(8'h0c, 32'h200 | 32'(1 << b));
      pins.pulse(5, 1);
      rv(8'h28, 32'(cr));
      pins.pulse(b == 12 ? 1 : 7, 1);
      rv(8'h28, 32'(v));
      cr = v;
    end
    // core_timer_two: reload every 8 ticks, latch clocks aux_c
    wr(8'h28, 32'hfff8);
    wr(va(4), 32'hfff8);
    wr(va(3), 32'h0);
    wr(8'h0c, 32'(S_LATCH) | 32'h8);
    wr(8'h2c, 32'h1ff);
    np = pc;
    wr(8'h10, 32'h6008);
    repeat (20) @(posedge clk_in);
    v = pc;
    repeat (160) @(posedge clk_in);
    chk_w("cmp_clk", 32'd10, 32'(pc - v));
    chk_w("t2_en", 32'h1, 32'(en2));
    wr(8'h10, 32'h0);
    repeat (6) @(posedge clk_in);
    rv(va(3), 32'(pc - np));
    chk_w("t2_out", 32'((pc - np) & 1), 32'(lat2));
    rv(8'h2c, 32'h110);
    // a low clock enable freezes the core and its prescaler for 40 edges
    wr(va(1), 32'h0);
    wr(8'h04, 32'h8);
    rd(va(1), d, r);
    v = d[15:0];
    tb = t0;
    @(posedge clk_in);
    en <= 1'b0;
    repeat (40) @(posedge clk_in);
    en <= 1'b1;
    align = 4;
    rd(va(1), d, r);
    align = 1;
    chk_w("frozen", 32'(v + (t0 - tb - 40) / 4), d);
    wr(8'h04, 32'h0);
    stop_test();
  end
endmodule // test_gtu_top
`default_nettype wire
